//--- src/clk_mult_halt_ctrl.sv
// Purpose: reference clock selection, multiplier control and halt sequencing
// Assumes: clocks are modelled as one-cycle ticks on clk; fast multiplier
//          rates are reported as selects and divide codes for the clock tree
// Notes:   control bits arrive as write strobes with data, no bus decode
`default_nettype none

`include "clk_ctrl_params.svh"

module clk_mult_halt_ctrl (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       init_ref_source_select,
  input  wire logic       ext_clk_pin,
  input  wire logic       ref_halve_enable,
  input  wire logic       multiplier_ctrl_reg_wr,
  input  wire logic [7:0] multiplier_ctrl_reg_wdata,
  input  wire logic       halt_reg_wr,
  input  wire logic [7:0] halt_reg_wdata,
  input  wire logic       pwm_timer_run,
  input  wire logic       pwm_counter_overflow,
  input  wire logic       wakeup_event,
  output logic [7:0]      multiplier_ctrl_reg_rdata,
  output logic            ref_source_select,
  output logic            osc_running,
  output logic            ref_tick,
  output logic            multiplier_ref_tick,
  output logic            instr_tick,
  output logic            multiplier_powered,
  output logic            multiplier_locked,
  output logic            pwm_fast_clk_active,
  output logic [1:0]      pwm_clk_divide_active,
  output logic            instr_fast_clk_active,
  output logic            halt_active,
  output logic            analog_enable,
  output logic            core_hold
);

  import clk_ctrl_pkg::*;

  localparam logic [`CNT_W-1:0] LOCK_LAST = `CNT_W'(`LOCK_CYCLES - 1);
  localparam logic [`CNT_W-1:0] REC_LAST  = `CNT_W'(`HALT_REC_CYCLES - 1);

  clk_ctrl_state_t q;
  clk_ctrl_state_t d;

  logic osc_tick;
  logic halved_tick;
  logic instr_div_tick;
  logic ref_raw;
  logic mc_en_w;
  logic mc_src_w;
  logic mc_fast_w;

  // ----------------------------------------------------------------------
  // tick dividers
  // ----------------------------------------------------------------------
  // oscillator model: stops whenever osc_run is low
  tick_divider #(
    .DIV      (`OSC_PERIOD_CYCLES)
  ) u_osc (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .clr      (!q.osc_run),
    .bypass   (1'b0),
    .tick_in  (1'b1),
    .tick_out (osc_tick)
  );

  tick_divider #(
    .DIV      (`REF_HALVE_DIV)
  ) u_ref_halve (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .clr      (1'b0),
    .bypass   (!ref_halve_enable),  // [R6]
    .tick_in  (q.ref_tick),
    .tick_out (halved_tick)
  );

  tick_divider #(
    .DIV      (`INSTR_DIV)
  ) u_instr_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .clr      (1'b0),
    .bypass   (1'b0),
    .tick_in  (q.ref_tick),  // [R4]
    .tick_out (instr_div_tick)
  );

  // ----------------------------------------------------------------------
  // write data fields
  // ----------------------------------------------------------------------
  assign mc_en_w   = multiplier_ctrl_reg_wdata[`MC_ENABLE_POS];
  assign mc_src_w  = multiplier_ctrl_reg_wdata[`MC_PWM_SRC_POS];
  assign mc_fast_w = multiplier_ctrl_reg_wdata[`MC_FAST_INSTR_POS];

  // external clock is only usable after two flops
  assign ref_raw = q.ref_src ? (q.ext_s2 && !q.ext_s3) : osc_tick;  // [R1]

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;

    // source select is caught once after reset release, never under reset
    if (!q.src_loaded)
    begin
      d.src_loaded = 1'b1;
      d.ref_src    = init_ref_source_select;  // [R2]
    end

    d.ext_s1 = ext_clk_pin;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;

    d.ref_tick      = ref_raw;
    d.mult_ref_tick = halved_tick;  // [R4] [R6]
    d.instr_tick    = instr_div_tick;  // [R4]

    // --------------------------------------------------------------------
    // multiplier control writes
    // --------------------------------------------------------------------
    if (multiplier_ctrl_reg_wr)
    begin
      if (!pwm_timer_run)
      begin
        d.mult_en = mc_en_w;  // [R10] [R8]
      end
      // a set attempt while disabled is dropped, clearing is allowed
      if (!pwm_timer_run && !(mc_src_w && !q.mult_en))
      begin
        d.pwm_src = mc_src_w;  // [R12]
      end
      d.fast_instr = q.mult_en ? mc_fast_w : 1'b0;  // [R16] [R17]
      d.div_sel    = multiplier_ctrl_reg_wdata[`MC_DIV_MSB:`MC_DIV_LSB];  // [R14]
    end

    // stopped timer follows at once; running timer waits for the cycle end
    if (!pwm_timer_run || pwm_counter_overflow)
    begin
      d.div_active = d.div_sel;  // [R13] [R7] [R5]
    end

    d.mc_rdata = 8'h00;
    d.mc_rdata[`MC_DIV_MSB:`MC_DIV_LSB] = d.div_sel;  // [R14]
    d.mc_rdata[`MC_PWM_SRC_POS]         = d.pwm_src;
    d.mc_rdata[`MC_FAST_INSTR_POS]      = d.fast_instr;
    d.mc_rdata[`MC_ENABLE_POS]          = d.mult_en;

    // --------------------------------------------------------------------
    // halt sequencing
    // --------------------------------------------------------------------
    case (q.hstate)
      ST_RUN:
      begin
        if (halt_reg_wr && halt_reg_wdata[`HALT_REQ_POS])
        begin
          d.hstate = ST_HALT;  // [R20] [R24]
        end
      end
      ST_HALT:
      begin
        if (wakeup_event)
        begin
          d.hstate  = ST_RECOVER;  // [R21]
          d.rec_cnt = '0;
        end
      end
      ST_RECOVER:
      begin
        if (q.rec_cnt == REC_LAST)
        begin
          d.hstate = ST_RUN;  // [R22]
        end
        else
        begin
          d.rec_cnt = q.rec_cnt + `CNT_W'(1);
        end
      end
      default:
      begin
        d.hstate = ST_RUN;
      end
    endcase

    d.core_hold = (d.hstate != ST_RUN);  // [R22]
    d.analog_on = (d.hstate != ST_HALT);  // [R20]
    d.osc_run   = (d.hstate != ST_HALT) && !d.ref_src;  // [R3]
    d.halted    = (d.hstate == ST_HALT);  // [R20]

    // --------------------------------------------------------------------
    // multiplier power and lock
    // --------------------------------------------------------------------
    d.mult_powered = d.mult_en && (d.hstate != ST_HALT);  // [R8]
    if (!d.mult_powered)
    begin
      d.lock_cnt = '0;
      d.locked   = 1'b0;  // [R8]
    end
    else if (!q.locked)
    begin
      if (q.lock_cnt == LOCK_LAST)
        d.locked = 1'b1;  // [R9]
      else
        d.lock_cnt = q.lock_cnt + `CNT_W'(1);
    end

    // --------------------------------------------------------------------
    // clock source switching
    // --------------------------------------------------------------------
    // only at an instruction clock edge so no period is cut short;
    // losing power drops the fast sources at once since nothing runs
    if (!d.mult_powered)
    begin
      d.pwm_src_eff    = 1'b0;  // [R8]
      d.fast_instr_eff = 1'b0;
    end
    else if (instr_div_tick)
    begin
      d.pwm_src_eff    = q.pwm_src;  // [R11] [R25]
      d.fast_instr_eff = q.fast_instr;  // [R15] [R25] [R17]
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q            <= '0;
      q.hstate     <= ST_RUN;
      q.div_sel    <= `MC_DIV_RESET;
      q.div_active <= `MC_DIV_RESET;
      q.analog_on  <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign multiplier_ctrl_reg_rdata = q.mc_rdata;
  assign ref_source_select         = q.ref_src;
  assign osc_running               = q.osc_run;
  assign ref_tick                  = q.ref_tick;
  assign multiplier_ref_tick       = q.mult_ref_tick;
  assign instr_tick                = q.instr_tick;
  assign multiplier_powered        = q.mult_powered;
  assign multiplier_locked         = q.locked;
  assign pwm_fast_clk_active       = q.pwm_src_eff;
  assign pwm_clk_divide_active     = q.div_active;
  assign instr_fast_clk_active     = q.fast_instr_eff;
  assign halt_active               = q.halted;
  assign analog_enable             = q.analog_on;
  assign core_hold                 = q.core_hold;

endmodule : clk_mult_halt_ctrl

`default_nettype wire

//--- src/clk_ctrl_params.svh
// Purpose: constants of the clock multiplier and halt control block
// Assumes: clk runs at 40 MHz
// Notes:   bit positions, timing counts and fixed ratios live here only
//
// How it works
// R1 - reference clock comes from the internal oscillator at 0, external pin at 1
// R2 - source select is loaded from init storage at reset, then rules the device
// R3 - oscillator runs after power-up except in halt or with external source
// R4 - reference feeds multiplier and comparator filter; halved it is the instruction clock
// R5 - multiplier scales reference by 32, then post-divides by 1, 2, 4 or 8
// R6 - halve enable divides reference by 2 before multiplier and filter
// R7 - pwm divide codes 00..11 give 8, 16, 32, 64 MHz from 2 MHz
// R8 - enable powers multiplier and starts locking; clearing stops all its clocks
// R9 - software waits the lock time before using any multiplier output
// R10 - multiplier enable writes are ignored while the pwm timer runs
// R11 - pwm timer clock is fast multiplier output at 1, instruction clock at 0
// R12 - pwm source cannot be set while disabled nor changed while timer runs
// R13 - divide written while running takes effect at the next counter overflow
// R14 - divide readback always shows the last value software wrote
// R15 - fast instruction select uses the divide-by-8 multiplier output, else reference/2
// R16 - writing fast instruction select while disabled forces it to 0
// R17 - instruction clock source may switch on the fly once multiplier is enabled
// R18 - software clears both selects before clearing enable in a later write
// R19 - software changes clocks only with the pwm timer stopped in pwm mode
// R20 - writing the halt bit enters halt, stops oscillator and analog; self-clears
// R21 - only a wakeup detector event leaves halt; software arms it first
// R22 - after wakeup, execution is held for the halt recovery delay
// R23 - software clears the power mode clear register by load-immediate after halt
// R24 - halt register sits at 0xB7: bit 0 halt, bit 1 idle, rest reserved; the code acts on bit 0 only and ignores the idle bit
// R25 - source switches happen at clock boundaries so no period is shortened
`ifndef CLK_CTRL_PARAMS_SVH
`define CLK_CTRL_PARAMS_SVH

// ----------------------------------------------------------------------
// halt register
// ----------------------------------------------------------------------
`define HALT_REG_ADDR      8'hB7
`define HALT_REQ_POS       0
`define IDLE_REQ_POS       1

// ----------------------------------------------------------------------
// multiplier control register layout and reset values
// ----------------------------------------------------------------------
`define MC_DIV_LSB         0
`define MC_DIV_MSB         1
`define MC_PWM_SRC_POS     2
`define MC_FAST_INSTR_POS  3
`define MC_ENABLE_POS      4
`define MC_DIV_RESET       2'h0
`define FAST_INSTR_DIV     2'h0

// ----------------------------------------------------------------------
// ratios and timing
// ----------------------------------------------------------------------
`define MULT_FACTOR        32
`define REF_HALVE_DIV      2
`define INSTR_DIV          2
`define OSC_PERIOD_CYCLES  20
`define CLK_FREQ_MHZ       40
`define CNT_W              12
`define LOCK_TIME_US       50
`define HALT_REC_US        100
`define LOCK_CYCLES        (`LOCK_TIME_US * `CLK_FREQ_MHZ)
`define HALT_REC_CYCLES    (`HALT_REC_US * `CLK_FREQ_MHZ)

`endif

//--- src/clk_ctrl_pkg.sv
// Purpose: types of the clock multiplier and halt control block
// Assumes: constants come from the params header
// Notes:   one packed struct carries all state of the top module
`default_nettype none

`include "clk_ctrl_params.svh"

package clk_ctrl_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_RECOVER} halt_state_t;

  typedef struct packed {
    logic                src_loaded;
    logic                ref_src;
    logic                ext_s1;
    logic                ext_s2;
    logic                ext_s3;
    logic                ref_tick;
    logic                mult_ref_tick;
    logic                instr_tick;
    logic                osc_run;
    logic                mult_en;
    logic                pwm_src;
    logic                fast_instr;
    logic [1:0]          div_sel;
    logic [1:0]          div_active;
    logic                pwm_src_eff;
    logic                fast_instr_eff;
    logic                mult_powered;
    logic                locked;
    logic [`CNT_W-1:0]   lock_cnt;
    halt_state_t         hstate;
    logic                halted;
    logic [`CNT_W-1:0]   rec_cnt;
    logic                core_hold;
    logic                analog_on;
    logic [7:0]          mc_rdata;
  } clk_ctrl_state_t;

endpackage : clk_ctrl_pkg

`default_nettype wire

//--- src/tick_divider.sv
// Purpose: divides a one-cycle tick stream by a fixed ratio
// Assumes: tick_in is a single-cycle pulse on clk
// Notes:   bypass passes each tick through with one cycle of latency
`default_nettype none

module tick_divider #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic bypass,
  input  wire logic tick_in,
  output logic      tick_out
);

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_state_t;

  div_state_t q;
  div_state_t d;

  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (clr)
    begin
      d.cnt = '0;
    end
    else if (tick_in)
    begin
      if (bypass)
      begin
        d.tick = 1'b1;
      end
      else if (q.cnt == LAST)
      begin
        d.cnt  = '0;
        d.tick = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign tick_out = q.tick;

endmodule : tick_divider

`default_nettype wire

//--- sim/clk_mult_halt_ctrl_chk.sv
// Purpose: port assertions for clk_mult_halt_ctrl
// Assumes: counts come from the params header
// Notes:   bound at the foot of this file
`default_nettype none
`include "clk_ctrl_params.svh"

module clk_mult_halt_ctrl_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ce,
  input wire logic       halt_reg_wr,
  input wire logic [7:0] halt_reg_wdata,
  input wire logic       multiplier_ctrl_reg_wr,
  input wire logic [7:0] multiplier_ctrl_reg_wdata,
  input wire logic       pwm_timer_run,
  input wire logic       pwm_counter_overflow,
  input wire logic       wakeup_event,
  input wire logic [7:0] multiplier_ctrl_reg_rdata,
  input wire logic       osc_running,
  input wire logic       multiplier_powered,
  input wire logic       multiplier_locked,
  input wire logic       pwm_fast_clk_active,
  input wire logic [1:0] pwm_clk_divide_active,
  input wire logic       instr_fast_clk_active,
  input wire logic       halt_active,
  input wire logic       analog_enable,
  input wire logic       core_hold
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int REC = `HALT_REC_CYCLES;
  wire         mw = multiplier_ctrl_reg_wr & ce;
  wire [7:0]   rd = multiplier_ctrl_reg_rdata;
  wire [7:0]   wd = multiplier_ctrl_reg_wdata;
  logic [12:0] rc_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // recovery length; frozen with ce as the design is
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      rc_q <= '0;
    else if (halt_active || !core_hold)
      rc_q <= '0;
    else if (ce)
      rc_q <= rc_q + 13'h1;

  // ----------
  // halt steps
  // ----------
  sequence s_halt_req;
    halt_reg_wr && halt_reg_wdata[0] && ce && !core_hold;
  endsequence
  sequence s_wake;
    halt_active && wakeup_event && ce;
  endsequence

  chk_halt_entry: assert property (s_halt_req |=>
    halt_active && core_hold && !analog_enable && !osc_running && !multiplier_powered)
    else $error("halt entry wrong");
  chk_halt_stay: assert property (halt_active && !wakeup_event |=> halt_active)
    else $error("halt left without wakeup");
  chk_wake_exit: assert property (s_wake |=> !halt_active && analog_enable && core_hold)
    else $error("wakeup exit wrong");
  chk_rec_span: assert property ($fell(core_hold) |-> rc_q == REC)
    else $error("recovery length wrong");
  chk_pwr_follow: assert property (mw && !pwm_timer_run && !core_hold && !halt_reg_wr
    |=> multiplier_powered == $past(wd[4])) else $error("power not following enable");
  chk_en_frozen: assert property (mw && pwm_timer_run |=> $stable(rd[4]))
    else $error("enable changed while running");
  chk_src_refuse: assert property (mw && (pwm_timer_run || !rd[4] && wd[2])
    |=> $stable(rd[2])) else $error("pwm source write not refused");
  chk_fast_force: assert property (mw && !rd[4] |=> !rd[3])
    else $error("fast select not forced low");
  chk_div_read: assert property (mw |=> rd[1:0] == $past(wd[1:0]))
    else $error("divide readback wrong");
  chk_div_hold: assert property (pwm_timer_run && !pwm_counter_overflow
    |=> $stable(pwm_clk_divide_active)) else $error("divide changed mid cycle");
  chk_div_ovf: assert property (pwm_timer_run && pwm_counter_overflow && ce
    |=> pwm_clk_divide_active == rd[1:0]) else $error("divide not taken at overflow");
  chk_off_sel: assert property (!multiplier_powered [*2] |-> !multiplier_locked
    && !pwm_fast_clk_active && !instr_fast_clk_active) else $error("outputs live unpowered");
endmodule : clk_mult_halt_ctrl_chk

bind clk_mult_halt_ctrl clk_mult_halt_ctrl_chk u_chk (.*);

`default_nettype wire

//--- sim/tb_top.sv
// Purpose: self-checking bench for clk_mult_halt_ctrl
// Assumes: tick period and counts from the params header
// Notes:   control writes are checked against a byte model
`default_nettype none
`include "clk_ctrl_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, sys_rst, ce, init_ref_source_select, ext_clk_pin, ext_run;
  logic       ref_halve_enable, multiplier_ctrl_reg_wr, halt_reg_wr, wakeup_event;
  logic       pwm_timer_run, pwm_counter_overflow, ref_source_select, osc_running;
  logic       ref_tick, multiplier_ref_tick, instr_tick, multiplier_powered;
  logic       multiplier_locked, pwm_fast_clk_active, instr_fast_clk_active;
  logic       halt_active, analog_enable, core_hold;
  logic [7:0] multiplier_ctrl_reg_wdata, halt_reg_wdata, multiplier_ctrl_reg_rdata, cur, d;
  logic [1:0] pwm_clk_divide_active, act;
  int         n_errors, checked, n, a, b, c;

  clk_mult_halt_ctrl u_clk_mult_halt_ctrl (.*);

  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // pin period six cycles; held still when not in use
  always #75 if (ext_run) ext_clk_pin = ~ext_clk_pin;

  // -------
  // helpers
  // -------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // byte model: refusals use the enable stored before the write
  function automatic logic [7:0] mc_exp(input logic [7:0] c, input logic [7:0] w,
                                        input logic r);
    return {3'h0, r ? c[4] : w[4], c[4] & w[3], (r || !c[4] && w[2]) ? c[2] : w[2], w[1:0]};
  endfunction : mc_exp

  function automatic logic sig(input int s);
    case (s)
      0: return multiplier_locked;
      1: return pwm_fast_clk_active;
      2: return instr_fast_clk_active;
      default: return core_hold;
    endcase
  endfunction : sig

  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("wait", 16'(sig(s)), 16'(v));
    if (n >= lim)
      end_sim();
  endtask : wt

  task automatic count(input int k);
    a = 0;
    b = 0;
    c = 0;
    repeat (k)
    begin
      @(negedge clk);
      a += int'(ref_tick);
      b += int'(multiplier_ref_tick);
      c += int'(instr_tick);
    end
  endtask : count

  task automatic mc_wr(input logic [7:0] w, input logic r, input logic o);
    multiplier_ctrl_reg_wr = 1'b1;
    multiplier_ctrl_reg_wdata = w;
    pwm_timer_run = r;
    pwm_counter_overflow = o;
    @(negedge clk);
    multiplier_ctrl_reg_wr = 1'b0;
    pwm_counter_overflow = 1'b0;
    cur = mc_exp(cur, w, r);
    if (!r || o)
      act = cur[1:0];
    @(negedge clk);
    chk("ctrl", 16'(multiplier_ctrl_reg_rdata), 16'(cur));
    chk("div", 16'(pwm_clk_divide_active), 16'(act));
    chk("pwr", 16'(multiplier_powered), 16'(cur[4]));
  endtask : mc_wr

  task automatic hw(input logic [7:0] v);
    halt_reg_wr = 1'b1;
    halt_reg_wdata = v;
    @(negedge clk);
    halt_reg_wr = 1'b0;
  endtask : hw

  // ---------
  // sequence
  // ---------
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {init_ref_source_select, ext_clk_pin, ext_run, ref_halve_enable} = 4'h0;
    {multiplier_ctrl_reg_wr, halt_reg_wr, wakeup_event} = 3'h0;
    {pwm_timer_run, pwm_counter_overflow} = 2'h0;
    multiplier_ctrl_reg_wdata = 8'h00;
    halt_reg_wdata = 8'h00;
    {cur, act, d} = 18'h00000;
    n_errors = 0;
    checked = 0;
    void'($urandom(32'h5A29));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("osc", 16'({ref_source_select, osc_running}), 16'h1);
    for (int h = 0; h < 2; h++)
    begin
      ref_halve_enable = h[0];
      repeat (100) @(negedge clk);
      count(40 * `OSC_PERIOD_CYCLES);
      chk("ref", 16'(a), 16'h28);
      chk("instr", 16'(c), 16'h14);
      chk("mref", 16'(b), h ? 16'h14 : 16'h28);
    end
    // frozen clock enable: a held write must not land, ticks must not move
    ce = 1'b0;
    multiplier_ctrl_reg_wr = 1'b1;
    multiplier_ctrl_reg_wdata = 8'h13;
    count(40);
    multiplier_ctrl_reg_wr = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    chk("frz_tick", 16'((a % 40) + (b % 40) + (c % 40)), 16'h0);
    chk("frz_ctrl", 16'(multiplier_ctrl_reg_rdata), 16'(cur));
    $display("ticks done");
    mc_wr(8'h10, 1'b0, 1'b0);
    wt(0, 1'b1, 3000);
    chk("lock", 16'((n + 1) inside {[`LOCK_CYCLES - 1:`LOCK_CYCLES + 1]}), 16'h1);
    mc_wr(8'h14, 1'b0, 1'b0);
    wt(1, 1'b1, 200);
    mc_wr(8'h1C, 1'b0, 1'b0);
    wt(2, 1'b1, 200);
    $display("lock done");
    mc_wr(8'h00, 1'b1, 1'b0);
    mc_wr(8'h13, 1'b1, 1'b0);
    mc_wr(8'h12, 1'b1, 1'b1);
    mc_wr(8'h10, 1'b0, 1'b0);
    mc_wr(8'h00, 1'b0, 1'b0);
    mc_wr(8'h0F, 1'b0, 1'b0);
    for (int i = 0; i < 60; i++)
    begin
      d = 8'($urandom);
      // selects go before the enable is cleared
      if (cur[4] && cur[3:2] != 2'h0)
        d[4] = 1'b1;
      mc_wr(d, 1'($urandom_range(1)), 1'($urandom_range(1)));
    end
    $display("control done");
    mc_wr(8'h10, 1'b0, 1'b0);
    mc_wr(8'h00, 1'b0, 1'b0);
    wakeup_event = 1'b1;
    @(negedge clk);
    wakeup_event = 1'b0;
    chk("nowake", 16'(core_hold), 16'h0);
    hw(8'h01);
    chk("halt", 16'({halt_active, core_hold, analog_enable, osc_running}), 16'hC);
    repeat (50) @(negedge clk);
    chk("stay", 16'(halt_active), 16'h1);
    wakeup_event = 1'b1;
    @(negedge clk);
    wakeup_event = 1'b0;
    chk("wake", 16'({halt_active, core_hold, analog_enable}), 16'h3);
    // power mode clear after wake is the core's own load, no port here
    hw(8'h03);
    chk("rehalt", 16'(halt_active), 16'h0);
    wt(3, 1'b0, 5000);
    chk("rec", 16'((n + 1) inside {[`HALT_REC_CYCLES - 1:`HALT_REC_CYCLES + 1]}), 16'h1);
    hw(8'hFE);
    chk("idle", 16'(halt_active), 16'h0);
    $display("halt done");
    init_ref_source_select = 1'b1;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    ext_run = 1'b1;
    {cur, act} = 10'h000;
    repeat (20) @(negedge clk);
    chk("ext", 16'({ref_source_select, osc_running}), 16'h2);
    count(600);
    chk("edges", 16'(a inside {[99:101]}), 16'h1);
    $display("external done");
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
